// [acfg_buf.sv]
// small valid/ready buffer between the sample source and the serializer
`timescale 1ns/1ps
`default_nettype none
module acfg_buf #(
	parameter int W     = 28,
	parameter int DEPTH = 2
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	output var  logic         in_ready,
	input  wire logic [W-1:0] in_data,
	output var  logic         out_valid,
	input  wire logic         out_ready,
	output var  logic [W-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          push;
	logic          pop;

	// handshakes and occupancy
	assign push       = in_valid && in_ready;
	assign pop        = out_valid && out_ready;
	assign next_count = count + CW'(push) - CW'(pop);
	assign out_data   = mem[rd_ptr];

	// storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and flags; full and empty are registered
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count     <= next_count;
			in_ready  <= (next_count != CW'(DEPTH));
			out_valid <= (next_count != '0);
		end
	end
endmodule : acfg_buf
`default_nettype wire

// [acfg_defines.svh]
// register map, field positions and reset values of the serial output configuration bank
`ifndef ACFG_DEFINES_SVH
`define ACFG_DEFINES_SVH

// ****************************************************************
// bus and register offsets
// ****************************************************************
`define ACFG_ADDR_W       5
`define ACFG_DATA_W       11
`define ACFG_OFS_CTRL     5'h00
`define ACFG_OFS_PAT_LOW  5'h0b
`define ACFG_OFS_GAIN_PAT 5'h0c
`define ACFG_OFS_FORMAT   5'h0d
`define ACFG_OFS_STATUS   5'h0e

// ****************************************************************
// field positions
// ****************************************************************
`define ACFG_CTRL_SRST    10
`define ACFG_FMT_TWO_LANE 0
`define ACFG_FMT_SDR      1
`define ACFG_FMT_WORD16   2
`define ACFG_FMT_RISE     4
`define ACFG_FMT_COARSE   5
`define ACFG_FMT_LSB      6
`define ACFG_FMT_BITWISE  7
`define ACFG_FMT_OVRD     10
`define ACFG_GAIN_LSB     8
`define ACFG_GAIN_MSB     10
`define ACFG_PATHI_MSB    4

// ****************************************************************
// masks, reset values and limits
// ****************************************************************
`define ACFG_FMT_MASK     11'h04f7
`define ACFG_GAIN_MASK    11'h071f
`define ACFG_PATLO_MASK   11'h07ff
`define ACFG_RESET_VAL    11'h0000
`define ACFG_GAIN_MAX     3'h6
`define ACFG_GAIN_RSVD    3'h7
`define ACFG_SMP_W        14

`endif

// [acfg_pkg.sv]
// types shared by the serial output configuration bank
`default_nettype none
package acfg_pkg;
	// serializer states, one-hot
	typedef enum logic [1:0] {
		st_idle  = 2'b01,
		st_shift = 2'b10
	} acfg_state_t;
endpackage : acfg_pkg
`default_nettype wire

// [acfg_rx_model.sv]
// receiver model: drives the link bit clock and reassembles words from one or two lanes
`timescale 1ns/1ps
`default_nettype none
module acfg_rx_model (
	input  wire logic        core_clk,
	input  wire logic        run,
	input  wire logic        lsb_first,
	input  wire logic [4:0]  nbits,
	input  wire logic [7:0]  link_fmt,
	input  wire logic [1:0]  lane_a,
	input  wire logic [1:0]  lane_b,
	input  wire logic        frame_out,
	output var  logic        bit_clk_in,
	output var  logic [15:0] word_a,
	output var  logic [15:0] word_b,
	output var  logic [7:0]  words
);
	logic [15:0] acc_a, acc_b;
	logic [15:0] acc_a1, acc_b1;
	logic        fr_q;
	int          n;
	// right-aligns one lane's bits whatever the bit order
	function automatic logic [15:0] align(input logic [15:0] x);
		return lsb_first ? x >> (16 - nbits) : x;
	endfunction : align
	// rebuilds the sample word from the two lane parts
	function automatic logic [15:0] merge(input logic [15:0] h0, input logic [15:0] h1);
		logic [15:0] m;
		m = h0;
		if (link_fmt[0] && link_fmt[7]) begin
			for (int i = 0; i < 8; i++) begin
				m[2 * i + 1] = h0[i];
				m[2 * i]     = h1[i];
			end
		end else if (link_fmt[0]) begin
			m = (h0 << nbits) | h1;
		end
		return m;
	endfunction : merge
	// bit clock toggles only while a transfer is wanted, offset from the core clock
	initial begin
		bit_clk_in = 1'b0;
		words = 8'h00;
		n = 99;
		fr_q = 1'b0;
		#13;
		forever #160 if (run) bit_clk_in = ~bit_clk_in;
	end
	// DDR samples on every edge, SDR only on the capture edge, half a bit after launch
	always @(bit_clk_in) begin
		repeat (2) @(posedge core_clk);
		if (!(link_fmt[0] && link_fmt[1]) || bit_clk_in == link_fmt[4]) begin
			if (frame_out && !fr_q) begin
				n = 0;
				acc_a = 16'h0000;
				acc_b = 16'h0000;
				acc_a1 = 16'h0000;
				acc_b1 = 16'h0000;
			end
			fr_q = frame_out;
			if (n < nbits) begin
				acc_a = lsb_first ? {lane_a[0], acc_a[15:1]} : {acc_a[14:0], lane_a[0]};
				acc_b = lsb_first ? {lane_b[0], acc_b[15:1]} : {acc_b[14:0], lane_b[0]};
				acc_a1 = lsb_first ? {lane_a[1], acc_a1[15:1]} : {acc_a1[14:0], lane_a[1]};
				acc_b1 = lsb_first ? {lane_b[1], acc_b1[15:1]} : {acc_b1[14:0], lane_b[1]};
				n++;
				if (n == nbits) begin
					word_a = merge(align(acc_a), align(acc_a1));
					word_b = merge(align(acc_b), align(acc_b1));
					words = words + 8'h01;
				end
			end
		end
	end
endmodule : acfg_rx_model
`default_nettype wire

// [acfg_sync.sv]
// two flip-flop synchroniser for levels from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module acfg_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : acfg_sync
`default_nettype wire

// [acfg_top.sv]
// serial output configuration bank with gain, test word and lane serializer
//
// Overview of operation
// [R1] gain register bits 4..0 are test word bits 15..11
// [R2] bits 10..8 set fine gain 0..6 dB
// [R3] bit 0 picks lanes, bit 1 DDR/SDR (here SDR only with two lanes; one lane is always DDR)
// [R4] bit 2 selects 14 or 16 bit words
// [R5] in SDR, bit 4 picks capture edge
// [R6] bit 5 enables fixed coarse gain
// [R7] bit 6 selects MSB or LSB first
// [R8] two lanes: bit 7 byte or bit split
// [R9] override bit makes register beat pins
// [R10] host writes zero to unused bits
// [R11] pattern low register holds bits 10..0
// [R12] software reset clears registers, then self-clears
// [R13] reserved gain code 111 holds 6 dB
//
// The implementer's own choice: the plain strobed port.
`include "acfg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acfg_top #(
	parameter int SMP_W = `ACFG_SMP_W
) (
	input  wire logic                    core_clk,
	input  wire logic                    reset_n,
	input  wire logic [`ACFG_ADDR_W-1:0] reg_addr,
	input  wire logic [`ACFG_DATA_W-1:0] reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output var  logic [`ACFG_DATA_W-1:0] reg_rdata,
	input  wire logic [7:0]              fmt_pins,
	input  wire logic                    bit_clk_in,
	input  wire logic                    smp_valid,
	output var  logic                    smp_ready,
	input  wire logic [SMP_W-1:0]        smp_a,
	input  wire logic [SMP_W-1:0]        smp_b,
	output var  logic [1:0]              lane_a,
	output var  logic [1:0]              lane_b,
	output var  logic                    frame_out,
	output var  logic [2:0]              fine_gain,
	output var  logic                    coarse_gain_en,
	output var  logic [15:0]             user_pattern
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [`ACFG_DATA_W-1:0] pat_low;
	logic [`ACFG_DATA_W-1:0] gain_and_pattern_high;
	logic [`ACFG_DATA_W-1:0] output_format_control;
	logic                    soft_rst;
	logic                    cfg_clear;
	logic [8:0]              pin_sync;
	logic [7:0]              pins_s;
	logic                    bck_s;
	logic                    bck_d;
	logic                    bck_rise;
	logic                    bck_fall;
	logic [7:0]              eff_fmt;
	logic [7:0]              act_fmt;
	logic [7:0]              cur_fmt;
	logic [4:0]              act_steps;
	logic [4:0]              next_steps;
	logic [3:0]              cnt;
	logic                    launch;
	logic                    load;
	logic                    shift;
	logic                    stop;
	logic                    busy;
	logic                    buf_valid;
	logic [2*SMP_W-1:0]      buf_data;
	logic [15:0]             word_a;
	logic [15:0]             word_b;
	logic [15:0]             seq [0:3];
	acfg_pkg::acfg_state_t   state;

	// ****************************************************************
	// functions
	// ****************************************************************

	// true when a bus access hits the given offset
	function automatic logic acfg_hit(
		input logic [`ACFG_ADDR_W-1:0] a,
		input logic [`ACFG_ADDR_W-1:0] ofs
	);
		return a == ofs;
	endfunction : acfg_hit

	// aligns a sample in a 16 bit word, msb at position len-1
	function automatic logic [15:0] acfg_word(
		input logic [SMP_W-1:0] s,
		input logic [7:0]       f
	);
		logic [15:0] w;
		w = 16'h0000;
		if (f[`ACFG_FMT_WORD16]) begin
			w = {s, 2'b00};                                    // [R4]
		end else begin
			w = {2'b00, s};
		end
		return w;
	endfunction : acfg_word

	// builds one lane's bit sequence, first bit out at position 15
	function automatic logic [15:0] acfg_seq(
		input logic [15:0] w,
		input logic [7:0]  f,
		input logic        ln
	);
		logic [15:0] s;
		int          len;
		int          half;
		int          num;
		int          pos;
		s    = 16'h0000;
		len  = f[`ACFG_FMT_WORD16] ? 16 : 14;                  // [R4]
		half = len / 2;
		num  = f[`ACFG_FMT_TWO_LANE] ? half : len;             // [R3]
		pos  = 0;
		for (int k = 0; k < 16; k++) begin
			if (!f[`ACFG_FMT_TWO_LANE]) begin
				pos = f[`ACFG_FMT_LSB] ? k : len - 1 - k;      // [R7]
			end else if (f[`ACFG_FMT_BITWISE]) begin
				// odd bits on lane 0, even bits on lane 1
				pos = f[`ACFG_FMT_LSB] ? 2 * k + (ln ? 0 : 1)
				                       : len - 1 - 2 * k - (ln ? 1 : 0); // [R8]
			end else if (!ln) begin
				// upper half on lane 0
				pos = f[`ACFG_FMT_LSB] ? half + k : len - 1 - k; // [R8]
			end else begin
				pos = f[`ACFG_FMT_LSB] ? k : half - 1 - k;
			end
			if (k < num && (f[`ACFG_FMT_TWO_LANE] || !ln)) begin
				s[15-k] = w[pos[3:0]];
			end
		end
		return s;
	endfunction : acfg_seq

	// ****************************************************************
	// input synchronisers
	// ****************************************************************

	// pins and bit clock come from outside the core clock domain
	acfg_sync #(
		.W (9)
	) u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in ({bit_clk_in, fmt_pins}),
		.sync_out (pin_sync)
	);

	assign pins_s = pin_sync[7:0];
	assign bck_s  = pin_sync[8];

	// edge finder on the synchronised bit clock
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			bck_d <= 1'b0;
		end else begin
			bck_d <= bck_s;
		end
	end

	assign bck_rise = bck_s && !bck_d;
	assign bck_fall = !bck_s && bck_d;

	// ****************************************************************
	// register bank
	// ****************************************************************

	// software reset pulse lasts one cycle, then clears itself
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= reg_wr && acfg_hit(reg_addr, `ACFG_OFS_CTRL)
			            && reg_wdata[`ACFG_CTRL_SRST] && !soft_rst; // [R12]
		end
	end

	assign cfg_clear = !reset_n || soft_rst;                   // [R12]

	// low part of the user test word
	always_ff @(posedge core_clk) begin
		if (cfg_clear) begin
			pat_low <= `ACFG_RESET_VAL;
		end else if (reg_wr && acfg_hit(reg_addr, `ACFG_OFS_PAT_LOW)) begin
			pat_low <= reg_wdata & `ACFG_PATLO_MASK;           // [R11]
		end
	end

	// fine gain and top of the user test word
	always_ff @(posedge core_clk) begin
		if (cfg_clear) begin
			gain_and_pattern_high <= `ACFG_RESET_VAL;
		end else if (reg_wr && acfg_hit(reg_addr, `ACFG_OFS_GAIN_PAT)) begin
			gain_and_pattern_high <= reg_wdata & `ACFG_GAIN_MASK; // [R10]
		end
	end

	// output format; reserved bits are dropped on write
	always_ff @(posedge core_clk) begin
		if (cfg_clear) begin
			output_format_control <= `ACFG_RESET_VAL;
		end else if (reg_wr && acfg_hit(reg_addr, `ACFG_OFS_FORMAT)) begin
			output_format_control <= reg_wdata & `ACFG_FMT_MASK; // [R10]
		end
	end

	// read data stand for one cycle after the strobe, else zero
	always_ff @(posedge core_clk) begin
		if (!reset_n || !reg_rd) begin
			reg_rdata <= `ACFG_RESET_VAL;
		end else begin
			unique case (reg_addr)
				`ACFG_OFS_CTRL:     reg_rdata <= {soft_rst, 10'h000};
				`ACFG_OFS_PAT_LOW:  reg_rdata <= pat_low;
				`ACFG_OFS_GAIN_PAT: reg_rdata <= gain_and_pattern_high;
				`ACFG_OFS_FORMAT:   reg_rdata <= output_format_control;
				`ACFG_OFS_STATUS:   reg_rdata <= {2'b00, busy, eff_fmt};
				default:            reg_rdata <= `ACFG_RESET_VAL;
			endcase
		end
	end

	// ****************************************************************
	// effective settings
	// ****************************************************************

	// override bit hands the format functions to the register
	assign eff_fmt = output_format_control[`ACFG_FMT_OVRD]
	                 ? output_format_control[7:0] : pins_s; // [R9]

	// gain and test word outputs
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			fine_gain      <= 3'h0;
			coarse_gain_en <= 1'b0;
			user_pattern   <= 16'h0000;
		end else begin
			if (gain_and_pattern_high[`ACFG_GAIN_MSB:`ACFG_GAIN_LSB] == `ACFG_GAIN_RSVD) begin
				fine_gain <= `ACFG_GAIN_MAX;                   // [R13]
			end else begin
				fine_gain <= gain_and_pattern_high[`ACFG_GAIN_MSB:`ACFG_GAIN_LSB]; // [R2]
			end
			coarse_gain_en <= eff_fmt[`ACFG_FMT_COARSE];        // [R6]
			user_pattern   <= {gain_and_pattern_high[`ACFG_PATHI_MSB:0],
			                   pat_low};                        // [R1] [R11]
		end
	end

	// ****************************************************************
	// sample buffer
	// ****************************************************************

	// two entries so a stall on the lanes loses no word
	acfg_buf #(
		.W     (2 * SMP_W),
		.DEPTH (2)
	) u_buf (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.in_valid  (smp_valid),
		.in_ready  (smp_ready),
		.in_data   ({smp_a, smp_b}),
		.out_valid (buf_valid),
		.out_ready (load),
		.out_data  (buf_data)
	);

	// ****************************************************************
	// serializer
	// ****************************************************************

	// a word in flight keeps the format it was loaded with
	assign busy    = (state == acfg_pkg::st_shift);
	assign cur_fmt = busy ? act_fmt : eff_fmt;

	// launch on the edge opposite the capture edge; DDR uses both
	always_comb begin
		if (cur_fmt[`ACFG_FMT_TWO_LANE] && cur_fmt[`ACFG_FMT_SDR]) begin // [R3]
			launch = cur_fmt[`ACFG_FMT_RISE] ? bck_fall : bck_rise; // [R5]
		end else begin
			launch = bck_rise || bck_fall;
		end
	end

	assign load  = launch && buf_valid && (!busy || cnt == 4'h0);
	assign shift = launch && busy && cnt != 4'h0;
	assign stop  = launch && busy && cnt == 4'h0 && !buf_valid;

	assign word_a = acfg_word(buf_data[2*SMP_W-1:SMP_W], eff_fmt);
	assign word_b = acfg_word(buf_data[SMP_W-1:0], eff_fmt);

	// bit steps per word on each lane
	always_comb begin
		if (eff_fmt[`ACFG_FMT_WORD16]) begin
			next_steps = eff_fmt[`ACFG_FMT_TWO_LANE] ? 5'h08 : 5'h10; // [R4]
		end else begin
			next_steps = eff_fmt[`ACFG_FMT_TWO_LANE] ? 5'h07 : 5'h0e;
		end
	end

	// state, remaining steps and latched format
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state     <= acfg_pkg::st_idle;
			cnt       <= 4'h0;
			act_fmt   <= 8'h00;
			act_steps <= 5'h00;
		end else if (load) begin
			state     <= acfg_pkg::st_shift;
			cnt       <= 4'(next_steps - 5'h01);
			act_fmt   <= eff_fmt;
			act_steps <= next_steps;
		end else if (shift) begin
			cnt <= cnt - 4'h1;
		end else if (stop) begin
			state <= acfg_pkg::st_idle;
		end
	end

	// frame marker is high for the first half of each word
	always_ff @(posedge core_clk) begin
		if (!reset_n || stop) begin
			frame_out <= 1'b0;
		end else if (load) begin
			frame_out <= 1'b1;
		end else if (shift) begin
			frame_out <= ({1'b0, cnt} - 5'h01) >= (act_steps >> 1);
		end
	end

	// one shift register per lane: channel a lanes 0..1, channel b 2..3
	for (genvar g = 0; g < 4; g++) begin : g_lane
		always_ff @(posedge core_clk) begin
			if (!reset_n || stop) begin
				seq[g] <= 16'h0000;
			end else if (load) begin
				seq[g] <= acfg_seq((g < 2) ? word_a : word_b, eff_fmt,
				                   (g % 2) == 1);              // [R7]
			end else if (shift) begin
				seq[g] <= {seq[g][14:0], 1'b0};
			end
		end
	end

	// lane pins come straight from the shift register heads
	assign lane_a = {seq[1][15], seq[0][15]};
	assign lane_b = {seq[3][15], seq[2][15]};

endmodule : acfg_top
`default_nettype wire

// [acfg_top_properties.sv]
// concurrent checks on the ports of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module acfg_top_checker (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [10:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [10:0] reg_rdata,
	input  wire logic        frame_out,
	input  wire logic [2:0]  fine_gain,
	input  wire logic        coarse_gain_en,
	input  wire logic [15:0] user_pattern
);
	// ****************************************
	// register and stream properties
	// ****************************************
	default clocking dcb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// four cycles without a write let registered outputs settle
	sequence quiet_s;
		(!reg_wr) [*4];
	endsequence
	sequence rd_s(ofs);
		reg_rd && reg_addr == ofs;
	endsequence
	// soft reset write, then a format read three cycles on
	sequence srst_s;
		reg_wr && reg_addr == 5'h00 && reg_wdata[10] ##3 rd_s(5'h0d);
	endsequence
	gain_read_a: assert property (
		quiet_s ##0 rd_s(5'h0c) |=>
		fine_gain == ((reg_rdata[10:8] == 3'h7) ? 3'h6 : reg_rdata[10:8]))
		else $error("fine gain differs from its field");
	gain_cap_a: assert property (fine_gain <= 3'h6)
		else $error("fine gain above six");
	pat_high_a: assert property (
		quiet_s ##0 rd_s(5'h0c) |=> user_pattern[15:11] == reg_rdata[4:0])
		else $error("pattern top bits differ from gain register");
	pat_low_a: assert property (
		quiet_s ##0 rd_s(5'h0b) |=> user_pattern[10:0] == reg_rdata)
		else $error("pattern low bits differ from register");
	pat_stable_a: assert property (quiet_s ##1 !reg_wr |-> $stable(user_pattern))
		else $error("pattern moved without a write");
	gain_mask_a: assert property (rd_s(5'h0c) |=> reg_rdata[7:5] == 3'h0)
		else $error("reserved gain bits read back set");
	fmt_mask_a: assert property (rd_s(5'h0d) |=> !reg_rdata[9] && !reg_rdata[8] && !reg_rdata[3])
		else $error("reserved format bits read back set");
	soft_reset_a: assert property (srst_s |=> reg_rdata == 11'h000)
		else $error("format not cleared by soft reset");
	coarse_ovrd_a: assert property (
		quiet_s ##0 rd_s(5'h0d) ##1 reg_rdata[10] |-> coarse_gain_en == reg_rdata[5])
		else $error("coarse gain ignores overriding register");
	frame_hold_a: assert property ($rose(frame_out) |-> frame_out [*4])
		else $error("frame marker too short");
endmodule : acfg_top_checker
bind acfg_top acfg_top_checker acfg_top_checker_i (.*);
`default_nettype wire

// [test_acfg_top.sv]
// self-checking bench for the serial output configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_acfg_top;
	logic        core_clk, reset_n, reg_wr, reg_rd, bit_clk_in, smp_valid, smp_ready;
	logic        frame_out, coarse_gain_en, run, lsb_first;
	logic [4:0]  reg_addr, nbits;
	logic [10:0] reg_wdata, reg_rdata;
	logic [7:0]  fmt_pins, words, link_fmt;
	logic [13:0] smp_a, smp_b;
	logic [1:0]  lane_a, lane_b;
	logic [2:0]  fine_gain;
	logic [15:0] user_pattern, word_a, word_b;
	int          num_errors, num_checks;

	acfg_top acfg_top_i (.*);
	acfg_rx_model acfg_rx_model_i (.*);
	// 25 MHz core clock
	always #20 core_clk = ~core_clk;

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results
	task automatic tmo(input string what);
		num_errors++;
		$display("[ERR] %s expected done seen timeout", what);
		results();
	endtask : tmo
	task automatic wr(input logic [4:0] a, input logic [10:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rdc(input logic [4:0] a, input logic [10:0] e, input string what);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, {5'h00, e}, {5'h00, reg_rdata});
	endtask : rdc
	task automatic push(input logic [13:0] a, input logic [13:0] b);
		int i;
		smp_a <= a;
		smp_b <= b;
		smp_valid <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (smp_ready !== 1'b1 && i < 500);
		smp_valid <= 1'b0;
		if (i >= 500) tmo("push");
	endtask : push
	function automatic logic [15:0] shape(input logic [13:0] s);
		return link_fmt[2] ? {s, 2'b00} : {2'b00, s};
	endfunction : shape
	task automatic await_word(input logic [13:0] sa, input logic [13:0] sb);
		logic [7:0] w0;
		int         i;
		w0 = words;
		run <= 1'b1;
		i = 0;
		while (words === w0 && i < 3000) begin
			@(posedge core_clk);
			i++;
		end
		if (i >= 3000) tmo("word");
		chk("lane a word", shape(sa), word_a);
		chk("lane b word", shape(sb), word_b);
	endtask : await_word

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		wr(5'h0b, 11'h7ff);
		wr(5'h0c, 11'h71f);
		wr(5'h0d, 11'h4f7);
		wr(5'h05, 11'h7ff);
		rdc(5'h0b, 11'h7ff, "pattern low");
		rdc(5'h0c, 11'h71f, "gain reg");
		rdc(5'h0d, 11'h4f7, "format reg");
		rdc(5'h05, 11'h000, "unmapped");
		$display("register test done");
	endtask : t_regs
	task automatic t_gain;
		logic [2:0] g;
		for (int i = 0; i < 8; i++) begin
			g = 3'(i);
			wr(5'h0c, {g, 3'h0, 5'h15});
			repeat (4) @(posedge core_clk);
			rdc(5'h0c, {g, 3'h0, 5'h15}, "gain read");
			chk("fine gain", (g == 3'h7) ? 16'h0006 : {13'h0, g}, {13'h0, fine_gain});
			chk("user pattern", {5'h15, 11'h7ff}, user_pattern);
		end
		$display("gain test done");
	endtask : t_gain
	task automatic t_coarse;
		fmt_pins <= 8'h00;
		wr(5'h0d, 11'h420);
		repeat (4) @(posedge core_clk);
		rdc(5'h0d, 11'h420, "format read");
		rdc(5'h0e, 11'h020, "status format");
		chk("coarse from reg", 16'h0001, {15'h0, coarse_gain_en});
		wr(5'h0d, 11'h020);
		repeat (6) @(posedge core_clk);
		chk("coarse pins low", 16'h0000, {15'h0, coarse_gain_en});
		fmt_pins <= 8'h20;
		repeat (6) @(posedge core_clk);
		chk("coarse pins high", 16'h0001, {15'h0, coarse_gain_en});
		$display("coarse test done");
	endtask : t_coarse
	task automatic t_srst;
		wr(5'h0c, 11'h315);
		wr(5'h00, 11'h400);
		@(posedge core_clk);
		@(posedge core_clk);
		rdc(5'h0d, 11'h000, "format after reset");
		rdc(5'h0c, 11'h000, "gain after reset");
		rdc(5'h0b, 11'h000, "pattern low after reset");
		rdc(5'h00, 11'h000, "reset bit");
		$display("soft reset test done");
	endtask : t_srst
	task automatic t_word(input logic [10:0] fmt, input logic [7:0] pins);
		logic [7:0] eff;
		eff = fmt[10] ? fmt[7:0] : pins;
		link_fmt = eff;
		nbits = (eff[2] ? 5'd16 : 5'd14) >> eff[0];
		lsb_first = eff[6];
		fmt_pins <= pins;
		wr(5'h0d, fmt);
		push(14'h2d3b, 14'h1c35);
		await_word(14'h2d3b, 14'h1c35);
		// one more bit period so an SDR launch edge ends the word
		repeat (8) @(posedge core_clk);
		run <= 1'b0;
		$display("word test %h done", fmt);
	endtask : t_word
	task automatic t_buf;
		push(14'h0aaa, 14'h1555);
		@(posedge core_clk);
		push(14'h3f00, 14'h00ff);
		repeat (2) @(posedge core_clk);
		chk("ready when full", 16'h0000, {15'h0, smp_ready}); // full buffer refuses
		await_word(14'h0aaa, 14'h1555);
		await_word(14'h3f00, 14'h00ff);
		run <= 1'b0;
		$display("buffer test done");
	endtask : t_buf

	// main sequence
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		{reg_wr, reg_rd, smp_valid, run, lsb_first} = 5'h00;
		reg_addr = 5'h00;
		reg_wdata = 11'h000;
		fmt_pins = 8'h00;
		smp_a = 14'h0000;
		smp_b = 14'h0000;
		nbits = 5'd14;
		link_fmt = 8'h00;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_gain();
		t_coarse();
		t_srst();
		t_word(11'h400, 8'h00);
		t_word(11'h444, 8'h00);
		t_word(11'h401, 8'h00);
		t_word(11'h4c7, 8'h00);
		t_word(11'h000, 8'h13);
		t_word(11'h000, 8'h04);
		t_buf();
		results();
	end
endmodule : test_acfg_top
`default_nettype wire
